// ==== design/tsp_core.sv ====
// Purpose: Two-wire serial port: slave stretching and master core
// Assumes: Lines are open-drain, sampled through two flip-flops
// Notes: Registers are flattened to plain ports
`timescale 1ns/100ps
module tsp_core
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_port_enable_bit,
    input wire logic [3:0] i_mode_select_field,
    input wire logic i_pin_direction_bits,
    input wire logic i_general_call_enable,
    input wire logic [7:0] i_address_or_reload_register,
    input wire logic i_addr_write,
    input wire logic [7:0] i_data_buffer,
    input wire logic i_buf_write,
    input wire logic i_buf_read,
    input wire logic i_release_set,
    input wire logic i_start_request_bit,
    input wire logic i_stop_request_bit,
    input wire logic i_receive_enable,
    input wire logic i_ack_send_level,
    input wire logic i_flag_clear,
    input wire logic i_collision_clear,
    input wire logic i_clock_line_n,
    input wire logic i_data_line_n,
    output logic o_clock_line_n,
    output logic o_clock_line_n_oe,
    output logic o_data_line_n,
    output logic o_data_line_n_oe,
    output logic [7:0] o_data_buffer,
    output logic o_buffer_full_flag,
    output logic o_address_update_flag,
    output logic o_clock_release_bit,
    output logic o_port_interrupt_flag,
    output logic o_write_collision_flag,
    output logic o_ack_received_status,
    output logic o_start_seen,
    output logic o_stop_seen,
    output logic o_read_not_write,
    output logic o_master_busy
);
    // ----------------------------------------------------------------
    // Line synchronisers and phase divider
    // ----------------------------------------------------------------
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [1:0] phase;
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            phase <= 2'h0;
        end
        else
        begin
            scl_s <= {scl_s[0], i_clock_line_n};
            sda_s <= {sda_s[0], i_data_line_n};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
            phase <= phase + 2'h1;
        end
    end
    wire scl = scl_s[1];
    wire sda = sda_s[1];
    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    wire start_det = scl && scl_d && sda_d && !sda;
    wire stop_det = scl && scl_d && !sda_d && sda;
    wire step = (phase == tsp_pkg::PHASE_TWO)
        || (phase == tsp_pkg::PHASE_FOUR);
    wire master_mode = i_port_enable_bit
        && (i_mode_select_field == tsp_pkg::MODE_MASTER);
    wire ten_bit = i_mode_select_field == tsp_pkg::MODE_SLAVE10;

    // ----------------------------------------------------------------
    // Master state and baud counter
    // ----------------------------------------------------------------
    tsp_pkg::master_state_type mst;
    tsp_pkg::master_state_type next_mst;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic m_rx;
    logic m_scl;
    logic m_sda;
    logic brg_zero;
    logic brg_load;
    logic brg_hold;
    wire in_start = (mst == tsp_pkg::M_START_A)
        || (mst == tsp_pkg::M_START_B);
    wire buf_accept = i_buf_write && !in_start;
    wire bit_high = mst == tsp_pkg::M_BIT_HIGH;
    assign brg_hold = bit_high && !scl;
    assign brg_load = (mst == tsp_pkg::M_IDLE) || (mst == tsp_pkg::M_WAIT)
        || brg_zero || (bit_high && scl_rise);
    tsp_baud u_baud
    (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_step(step),
        .i_load(brg_load),
        .i_hold(brg_hold),
        .i_reload(i_address_or_reload_register[6:0]),
        .o_zero(brg_zero)
    );
    wire byte_done = bit_high && brg_zero && (bitn == tsp_pkg::ACK_BIT);
    always_comb
    begin
        next_mst = mst;
        unique case (mst)
            tsp_pkg::M_IDLE:
                if (master_mode && i_start_request_bit && scl && sda)
                    next_mst = tsp_pkg::M_START_A;
            tsp_pkg::M_START_A:
                if (brg_zero)
                    next_mst = tsp_pkg::M_START_B;
            tsp_pkg::M_START_B:
                if (brg_zero)
                    next_mst = tsp_pkg::M_WAIT;
            tsp_pkg::M_WAIT:
                if (!master_mode)
                    next_mst = tsp_pkg::M_IDLE;
                else if (i_stop_request_bit && !o_port_interrupt_flag)
                    next_mst = tsp_pkg::M_STOP_A;
                else if (i_start_request_bit && !o_port_interrupt_flag)
                    next_mst = tsp_pkg::M_START_A;
                else if (buf_accept || i_receive_enable)
                    next_mst = tsp_pkg::M_BIT_LOW;
            tsp_pkg::M_BIT_LOW:
                if (brg_zero)
                    next_mst = tsp_pkg::M_BIT_HIGH;
            tsp_pkg::M_BIT_HIGH:
                if (brg_zero)
                    next_mst = byte_done ? tsp_pkg::M_WAIT
                        : tsp_pkg::M_BIT_LOW;
            tsp_pkg::M_STOP_A:
                if (brg_zero)
                    next_mst = tsp_pkg::M_STOP_B;
            tsp_pkg::M_STOP_B:
                if (brg_zero)
                    next_mst = tsp_pkg::M_STOP_C;
            tsp_pkg::M_STOP_C:
                if (brg_zero)
                    next_mst = tsp_pkg::M_IDLE;
            default:
                next_mst = tsp_pkg::M_IDLE;
        endcase
    end
    wire m_evt = master_mode && brg_zero && ((mst == tsp_pkg::M_START_B)
        || (mst == tsp_pkg::M_STOP_C) || byte_done);

    // ----------------------------------------------------------------
    // Slave receive path
    // ----------------------------------------------------------------
    logic [3:0] s_cnt;
    logic [7:0] s_sr;
    logic s_active;
    logic s_match;
    logic s_tx;
    logic [1:0] s_addr_seq;
    logic s_gc;
    wire [7:0] s_byte = {s_sr[6:0], sda};
    wire own7 = s_byte[7:1] == i_address_or_reload_register[7:1];
    wire gc_hit = i_general_call_enable
        && (s_byte == tsp_pkg::GENERAL_CALL);
    wire hdr_hit = s_byte[7:3] == tsp_pkg::TEN_BIT_HDR;
    wire s_eighth = s_active && scl_rise && (s_cnt == 4'h7);
    wire s_ninth_fall = s_active && scl_fall
        && (s_cnt == tsp_pkg::ACK_BIT);
    wire first_byte = s_addr_seq == 2'h0;
    wire addr_match = first_byte ? (gc_hit
        || (ten_bit ? hdr_hit : own7)) : s_match;
    wire set_ua = s_eighth && ten_bit && !s_gc && !gc_hit
        && ((first_byte && hdr_hit && !s_byte[0])
        || (s_addr_seq == 2'h1));
    wire third_rd = s_eighth && ten_bit && (s_addr_seq == 2'h2)
        && hdr_hit && s_byte[0];
    wire s_stretch = s_ninth_fall && s_match
        && (s_tx ? !o_buffer_full_flag && !buf_accept
        : (o_buffer_full_flag && i_start_request_bit));
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            s_cnt <= 4'h0;
            s_sr <= 8'h00;
            s_active <= 1'b0;
            s_match <= 1'b0;
            s_tx <= 1'b0;
            s_addr_seq <= 2'h0;
            s_gc <= 1'b0;
        end
        else if (start_det || stop_det || master_mode)
        begin
            s_cnt <= 4'h0;
            s_active <= start_det && !master_mode && i_port_enable_bit;
            s_match <= 1'b0;
            s_tx <= 1'b0;
            s_addr_seq <= 2'h0;
            s_gc <= 1'b0;
        end
        else if (s_active)
        begin
            if (scl_rise && s_cnt < tsp_pkg::BITS_PER_BYTE)
                s_sr <= s_byte;
            if (scl_rise)
                s_cnt <= s_cnt + 4'h1;
            if (s_ninth_fall)
                s_cnt <= 4'h0;
            if (s_eighth && s_addr_seq != 2'h3)
            begin
                s_match <= addr_match;
                s_gc <= first_byte && gc_hit;
                s_addr_seq <= (gc_hit || !ten_bit || third_rd)
                    ? 2'h3 : s_addr_seq + 2'h1;
                s_tx <= third_rd || (!ten_bit && own7 && s_byte[0]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Shared flags and line drivers
    // ----------------------------------------------------------------
    wire shift_out = (mst == tsp_pkg::M_BIT_LOW) && brg_zero;
    always_ff @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            mst <= tsp_pkg::M_IDLE;
            bitn <= 4'h0;
            shreg <= 8'h00;
            m_rx <= 1'b0;
            m_scl <= 1'b1;
            m_sda <= 1'b1;
            o_clock_line_n <= 1'b0;
            o_clock_line_n_oe <= 1'b0;
            o_data_line_n <= 1'b0;
            o_data_line_n_oe <= 1'b0;
            o_data_buffer <= 8'h00;
            o_buffer_full_flag <= 1'b0;
            o_address_update_flag <= 1'b0;
            o_clock_release_bit <= 1'b1;
            o_port_interrupt_flag <= 1'b0;
            o_write_collision_flag <= 1'b0;
            o_ack_received_status <= 1'b1;
            o_start_seen <= 1'b0;
            o_stop_seen <= 1'b0;
            o_read_not_write <= 1'b0;
            o_master_busy <= 1'b0;
        end
        else
        begin
            mst <= next_mst;
            o_master_busy <= next_mst != tsp_pkg::M_IDLE;
            if (!i_port_enable_bit)
            begin
                o_start_seen <= 1'b0;
                o_stop_seen <= 1'b0;
            end
            else if (start_det || stop_det)
            begin
                o_start_seen <= start_det;
                o_stop_seen <= stop_det;
            end
            if (mst == tsp_pkg::M_WAIT && buf_accept)
            begin
                shreg <= i_data_buffer;
                m_rx <= 1'b0;
                bitn <= 4'h0;
            end
            else if (mst == tsp_pkg::M_WAIT && i_receive_enable)
            begin
                m_rx <= 1'b1;
                bitn <= 4'h0;
            end
            if (mst == tsp_pkg::M_START_A && brg_zero)
                m_sda <= 1'b0;
            if (mst == tsp_pkg::M_STOP_A && brg_zero)
                m_scl <= 1'b1;
            if (mst == tsp_pkg::M_STOP_B && brg_zero)
                m_sda <= 1'b1;
            if ((mst == tsp_pkg::M_STOP_A && !brg_zero)
                || (mst == tsp_pkg::M_START_B && brg_zero) || shift_out)
                m_scl <= 1'b0;
            if (mst == tsp_pkg::M_STOP_A)
                m_sda <= 1'b0;
            if (shift_out)
            begin
                bitn <= bitn + 4'h1;
                if (bitn < tsp_pkg::BITS_PER_BYTE)
                    m_sda <= m_rx ? 1'b1 : shreg[7];
                else
                    m_sda <= m_rx ? i_ack_send_level : 1'b1;
            end
            // Release a cycle after the data bit moves, for setup time
            if (bit_high && !m_scl)
                m_scl <= 1'b1;
            if (bit_high && brg_zero && !byte_done)
                m_scl <= 1'b0;
            if (bit_high && brg_zero && byte_done)
                m_scl <= 1'b0;
            if (bit_high && scl_rise && bitn <= tsp_pkg::BITS_PER_BYTE)
                shreg <= {shreg[6:0], sda};
            if (bit_high && scl_rise && bitn == tsp_pkg::ACK_BIT && !m_rx)
                o_ack_received_status <= sda;
            if (bit_high && brg_zero && bitn == tsp_pkg::BITS_PER_BYTE)
                o_buffer_full_flag <= m_rx;
            if (m_rx && byte_done)
                o_data_buffer <= shreg;
            else if (s_eighth && addr_match && !s_tx)
                o_data_buffer <= s_byte;
            if (s_eighth && addr_match && !s_tx)
                o_buffer_full_flag <= 1'b1;
            else if (buf_accept)
                o_buffer_full_flag <= 1'b1;
            else if (i_buf_read || (s_active && s_tx && s_ninth_fall))
                o_buffer_full_flag <= 1'b0;
            if (s_eighth && addr_match)
                o_read_not_write <= s_byte[0];
            if (set_ua)
                o_address_update_flag <= 1'b1;
            else if (i_addr_write)
                o_address_update_flag <= 1'b0;
            if (m_evt || (s_ninth_fall && s_match))
                o_port_interrupt_flag <= 1'b1;
            else if (i_flag_clear)
                o_port_interrupt_flag <= 1'b0;
            if (i_buf_write && in_start)
                o_write_collision_flag <= 1'b1;
            else if (i_collision_clear)
                o_write_collision_flag <= 1'b0;
            if (s_stretch || (s_ninth_fall && s_tx && !o_buffer_full_flag))
                o_clock_release_bit <= 1'b0;
            else if (i_release_set)
                o_clock_release_bit <= 1'b1;
            if (master_mode)
            begin
                o_clock_line_n_oe <= i_pin_direction_bits && !m_scl;
                o_data_line_n_oe <= i_pin_direction_bits && !m_sda;
            end
            else
            begin
                // Drive low only once the line is already seen low
                o_clock_line_n_oe <= (!o_clock_line_n_oe ? !scl : 1'b1)
                    && (!o_clock_release_bit
                    || (set_ua || o_address_update_flag));
                o_data_line_n_oe <= s_active && ((s_cnt == 4'h8 && s_match
                    && !s_tx) || (s_tx && s_cnt < 4'h8
                    && !o_data_buffer[3'h7 - s_cnt[2:0]]));
            end
        end
    end
endmodule // tsp_core

// ==== design/tsp_pkg.sv ====
// Purpose: Shared constants and types for the two-wire serial port core
// Assumes: 125 MHz system clock, four phases per instruction cycle
// Notes: Mode encodings and phase counts are plain defaults
package tsp_pkg;
    // ----------------------------------------------------------------
    // Mode select encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_SLAVE7 = 4'h6;
    localparam logic [3:0] MODE_SLAVE10 = 4'h7;
    localparam logic [3:0] MODE_MASTER = 4'h8;
    // ----------------------------------------------------------------
    // Timing, bit counts and address constants
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 125000000;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_TWO = 2'h1;
    localparam logic [1:0] PHASE_FOUR = 2'h3;
    localparam logic [6:0] RELOAD_RST = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h9;
    localparam logic [7:0] GENERAL_CALL = 8'h00;
    localparam logic [4:0] TEN_BIT_HDR = 5'h1e;

    typedef enum logic [3:0]
    {
        M_IDLE = 4'h0,
        M_START_A = 4'h1,
        M_START_B = 4'h2,
        M_WAIT = 4'h3,
        M_BIT_LOW = 4'h4,
        M_BIT_HIGH = 4'h5,
        M_STOP_A = 4'h6,
        M_STOP_B = 4'h7,
        M_STOP_C = 4'h8
    } master_state_type;
endpackage

// ==== design/tsp_baud.sv ====
// Purpose: Down-counting baud counter stepped on phase two and four
// Assumes: Phase enable pulses come from the top module
// Notes: Halts at zero until reloaded
`timescale 1ns/100ps
module tsp_baud
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_step,
    input wire logic i_load,
    input wire logic i_hold,
    input wire logic [6:0] i_reload,
    output logic o_zero
);
    logic [6:0] count;
    wire is_zero = (count == 7'h00);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count <= tsp_pkg::RELOAD_RST;
            o_zero <= 1'b0;
        end
        else
        begin
            if (i_load)
                count <= i_reload;
            else if (i_step && !i_hold && !is_zero)
                count <= count - 7'h01;
            o_zero <= !i_load && !i_hold && is_zero;
        end
    end
endmodule // tsp_baud

// ==== testbench/tsp_core_chk.sv ====
// Purpose: Assertions on the ports of the two-wire serial port core
// Assumes: One clock domain, asynchronous active-high reset
// Notes: The clock stretch check only fires when master mode is off
`timescale 1ns/100ps
module tsp_core_chk
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_port_enable_bit,
    input wire logic [3:0] i_mode_select_field,
    input wire logic i_pin_direction_bits,
    input wire logic i_buf_write,
    input wire logic i_start_request_bit,
    input wire logic i_stop_request_bit,
    input wire logic i_flag_clear,
    input wire logic i_clock_line_n,
    input wire logic i_data_line_n,
    input wire logic o_clock_line_n_oe,
    input wire logic o_data_line_n_oe,
    input wire logic [7:0] o_data_buffer,
    input wire logic o_port_interrupt_flag,
    input wire logic o_write_collision_flag,
    input wire logic o_start_seen,
    input wire logic o_stop_seen
);
    // ------------------------------------------------------------
    // Shared terms
    // ------------------------------------------------------------
    wire logic master_on;
    wire logic start_pending;
    assign master_on = i_port_enable_bit &&
        (i_mode_select_field == tsp_pkg::MODE_MASTER);
    assign start_pending = master_on && i_start_request_bit &&
        !o_port_interrupt_flag;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    write_collision_flag_set_a: assert property (start_pending && i_buf_write
        |=> o_write_collision_flag) else $error("Collision not flagged");
    write_collision_flag_drop_a: assert property (start_pending && i_buf_write
        |=> $stable(o_data_buffer)) else $error("Dropped write landed");
    seen_clear_a: assert property (!i_port_enable_bit
        |=> !o_start_seen && !o_stop_seen) else $error("Seen bits kept");
    no_drive_a: assert property (!i_pin_direction_bits
        |=> !o_clock_line_n_oe && !o_data_line_n_oe)
        else $error("Drive without pin direction");
    flag_sticky_a: assert property (o_port_interrupt_flag &&
        !i_flag_clear |=> o_port_interrupt_flag) else $error("Flag lost");
    start_done_a: assert property ($rose(o_port_interrupt_flag) &&
        i_start_request_bit |-> o_data_line_n_oe && !o_clock_line_n_oe)
        else $error("Start flag without start held");
    stop_done_a: assert property ($rose(o_port_interrupt_flag) &&
        i_stop_request_bit |-> i_clock_line_n && i_data_line_n)
        else $error("Stop flag before lines high");
    byte_hold_a: assert property (master_on &&
        o_port_interrupt_flag && $past(o_port_interrupt_flag) &&
        !i_start_request_bit && !i_stop_request_bit && !i_buf_write &&
        i_pin_direction_bits |=> $stable(o_clock_line_n_oe))
        else $error("Clock moved while idle");
    ckp_low_a: assert property ($rose(o_clock_line_n_oe) &&
        !master_on |-> $past(i_clock_line_n) == 1'b0)
        else $error("Stretch on high");
endmodule // tsp_core_chk
bind tsp_core tsp_core_chk tsp_core_chk_i (.I_CLK(I_CLK),
    .I_SYS_RST(I_SYS_RST), .i_port_enable_bit(i_port_enable_bit),
    .i_mode_select_field(i_mode_select_field),
    .i_pin_direction_bits(i_pin_direction_bits), .i_buf_write(i_buf_write),
    .i_start_request_bit(i_start_request_bit),
    .i_stop_request_bit(i_stop_request_bit), .i_flag_clear(i_flag_clear),
    .i_clock_line_n(i_clock_line_n), .i_data_line_n(i_data_line_n),
    .o_clock_line_n_oe(o_clock_line_n_oe),
    .o_data_line_n_oe(o_data_line_n_oe), .o_data_buffer(o_data_buffer),
    .o_port_interrupt_flag(o_port_interrupt_flag),
    .o_write_collision_flag(o_write_collision_flag),
    .o_start_seen(o_start_seen), .o_stop_seen(o_stop_seen));

// ==== testbench/tsp_slave_model.sv ====
// Purpose: Behavioural slave on the far side of the two-wire bus
// Assumes: Lines are wired-AND with pull-ups in the bench
// Notes: Acks each byte while enabled; may stretch the ninth clock
`timescale 1ns/100ps
module tsp_slave_model
(
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_ack_en,
    input wire logic i_stretch,
    output logic o_sda_oe,
    output logic o_scl_oe,
    output logic [7:0] o_byte
);
    int bits;
    logic [7:0] shift;
    initial
    begin
        o_sda_oe = 1'b0;
        o_scl_oe = 1'b0;
        o_byte = 8'h00;
        bits = 10;
        shift = 8'h00;
    end
    // Idle until a start, so power-up edges shift nothing
    always @(negedge i_sda)
        if (i_scl === 1'b1)
            bits = 0;
    always @(posedge i_scl)
        if (bits < 8)
        begin
            shift = {shift[6:0], i_sda};
            bits++;
        end
    // Data only moves while the clock is low
    always @(negedge i_scl)
        if (bits == 8)
        begin
            o_byte = shift;
            o_sda_oe = i_ack_en;
            bits = 9;
            if (i_stretch)
            begin
                o_scl_oe = 1'b1;
                #500 o_scl_oe = 1'b0;
            end
        end
        else if (bits == 9)
        begin
            o_sda_oe = 1'b0;
            bits = 0;
        end
endmodule // tsp_slave_model

// ==== testbench/tsp_core_test.sv ====
// Purpose: Self-checking bench for the serial port master core
// Assumes: Slave model on the far side, pull-ups on both lines
// Notes: Slave receive paths are left to the assertions
`timescale 1ns/100ps
module tsp_core_test;
    localparam logic [6:0] SL_ADDR = 7'h2a;
    logic I_CLK = 1'b0;
    logic I_SYS_RST = 1'b1;
    logic en = 1'b0, pin = 1'b0, awr = 1'b0, bwr = 1'b0;
    logic sreq = 1'b0, preq = 1'b0, fclr = 1'b0, cclr = 1'b0;
    logic ack_en = 1'b1, stretch = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic scl, sda, scl_oe, sda_oe, sl_scl_oe, sl_sda_oe;
    logic rel, flag, write_collision_flag, ack_stat, sseen, pseen;
    logic [7:0] sl_byte;
    logic [31:0] seed = 32'h0000002a;
    int err_count = 0;
    int n_checks = 0;
    logic [7:0] exp_q[$];
    assign scl = ~(scl_oe | sl_scl_oe);
    assign sda = ~(sda_oe | sl_sda_oe);
    always #4 I_CLK = ~I_CLK;
    tsp_core tsp_core_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
        .i_port_enable_bit(en), .i_mode_select_field(mode),
        .i_pin_direction_bits(pin), .i_general_call_enable(1'b0),
        .i_address_or_reload_register(addr), .i_addr_write(awr),
        .i_data_buffer(wdata), .i_buf_write(bwr), .i_buf_read(1'b0),
        .i_release_set(1'b0), .i_start_request_bit(sreq),
        .i_stop_request_bit(preq), .i_receive_enable(1'b0),
        .i_ack_send_level(1'b0), .i_flag_clear(fclr),
        .i_collision_clear(cclr), .i_clock_line_n(scl), .i_data_line_n(sda),
        .o_clock_line_n(), .o_clock_line_n_oe(scl_oe), .o_data_line_n(),
        .o_data_line_n_oe(sda_oe), .o_data_buffer(), .o_buffer_full_flag(),
        .o_address_update_flag(), .o_clock_release_bit(rel),
        .o_port_interrupt_flag(flag), .o_write_collision_flag(write_collision_flag),
        .o_ack_received_status(ack_stat), .o_start_seen(sseen),
        .o_stop_seen(pseen), .o_read_not_write(), .o_master_busy());
    tsp_slave_model tsp_slave_model_i (.i_scl(scl), .i_sda(sda),
        .i_ack_en(ack_en), .i_stretch(stretch), .o_sda_oe(sl_sda_oe),
        .o_scl_oe(sl_scl_oe), .o_byte(sl_byte));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Sampled on the falling edge so the flag has settled
    task automatic wait_flag(input string what);
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 3000)
        begin
            @(negedge I_CLK);
            n++;
        end
        check(n < 3000, what);
    endtask
    task automatic clear_flag();
        @(posedge I_CLK);
        fclr <= 1'b1;
        cclr <= 1'b1;
        sreq <= 1'b0;
        preq <= 1'b0;
        @(posedge I_CLK);
        fclr <= 1'b0;
        cclr <= 1'b0;
        @(negedge I_CLK);
        check(flag === 1'b0 && write_collision_flag === 1'b0, "flags not cleared");
    endtask
    task automatic send_byte(input logic [7:0] b, input logic ack);
        @(posedge I_CLK);
        ack_en <= ack;
        wdata <= b;
        bwr <= 1'b1;
        exp_q.push_back(b);
        @(posedge I_CLK);
        bwr <= 1'b0;
        wait_flag("no flag after byte");
        check(sl_byte === exp_q.pop_front(), "byte on wire");
        check(ack_stat === ~ack, "ack status");
        clear_flag();
        $display("test byte done");
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(negedge I_CLK);
        check(scl_oe === 1'b0 && sda_oe === 1'b0 && ack_stat === 1'b1 &&
            rel === 1'b1, "reset values");
        @(posedge I_CLK);
        I_SYS_RST <= 1'b0;
        repeat (3) @(posedge I_CLK);
        en <= 1'b1;
        pin <= 1'b1;
        mode <= tsp_pkg::MODE_MASTER;
        addr <= {1'b0, 7'(rnd() % 4 + 2)};
        awr <= 1'b1;
        @(posedge I_CLK);
        awr <= 1'b0;
        sreq <= 1'b1; // bus idle since reset
        repeat (2) @(posedge I_CLK);
        wdata <= 8'hff;
        bwr <= 1'b1;
        @(posedge I_CLK);
        bwr <= 1'b0;
        wait_flag("no start flag");
        check({write_collision_flag, sseen} === 2'h3, "start and collision");
        clear_flag();
        $display("test start done");
        send_byte({SL_ADDR, 1'b0}, 1'b1);
        stretch <= 1'b1;
        send_byte(8'(rnd()), 1'b1);
        stretch <= 1'b0;
        send_byte(8'(rnd()), 1'b0);
        @(posedge I_CLK);
        preq <= 1'b1;
        wait_flag("no stop flag");
        check({pseen, scl, sda} === 3'h7, "stop");
        clear_flag();
        @(posedge I_CLK);
        en <= 1'b0;
        pin <= 1'b0;
        repeat (2) @(negedge I_CLK);
        check(sseen === 1'b0 && pseen === 1'b0, "seen bits");
        check(scl_oe === 1'b0 && sda_oe === 1'b0, "pins driven");
        $display("test stop done");
        report_and_stop();
    end
    // Longest run is a few hundred cycles; this leaves wide margin
    initial
    begin
        repeat (20000) @(posedge I_CLK);
        err_count++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        report_and_stop();
    end
endmodule // tsp_core_test
